// ==== design/drc_pkg.sv ====
// Constants, register map and state encoding for the device reset control
package drc_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int NUM_CH   = 16;
    localparam int AW       = 12;
    localparam int IDX_W    = 10;
    localparam int CNT_W    = 15;
    localparam int CH_CNT_W = 5;
    localparam int GPIO_N   = 2;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS  = 50;
    localparam int POR_TIME_MS    = 1;
    localparam int POR_CYC        = POR_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int SW_RST_TIME_US = 1;
    localparam int SW_RST_CYC     = SW_RST_TIME_US * 1000 / CLK_PERIOD_NS;

    // ****************************************
    // Register indices (byte address = index * 4)
    // ****************************************
    localparam logic [IDX_W-1:0] IDX_GLOB_RST = 10'h040;
    localparam logic [IDX_W-1:0] IDX_CH_CFG   = 10'h001;
    localparam logic [IDX_W-1:0] IDX_STATUS   = 10'h3fc;
    localparam logic [IDX_W-1:0] IDX_IOCTL    = 10'h3fd;
    localparam int               CH_IDX_LSB   = 6;

    // ****************************************
    // Field positions and defaults
    // ****************************************
    localparam int CF_STD      = 0;
    localparam int CF_RST      = 1;
    localparam int CF_SYS      = 2;
    localparam int CF_IE       = 3;
    localparam int IO_GPIO_LSB = 0;
    localparam int IO_DBUS     = 2;
    localparam int ST_POR_DONE = 0;
    localparam int ST_HW       = 1;
    localparam int ST_MCLK     = 2;
    localparam int ST_CH_LSB   = 16;
    localparam int GRST_W      = 8;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************
    // Global reset sequencer states
    // ****************************************
    typedef enum logic [2:0] {
        DRC_POR_WAIT = 3'b000,
        DRC_POR_CNT  = 3'b001,
        DRC_RUN      = 3'b010,
        DRC_HW       = 3'b011,
        DRC_GSW      = 3'b100
    } drc_state_t;

endpackage

// ==== design/drc_top.sv ====
// Reset sequencer with AXI4-Lite register access for a 16 channel device
// Functional notes
// - Four reset sources: power-on, pin, global software write, channel bit.
// - Power-on, pin and global software resets reset common and channel logic.
// - Channel software reset touches only the addressed channel.
// - Line pins of affected channels are high impedance during any reset.
// - After reset channels use T1/J1 line standard; channel reset keeps select.
// - After reset the system side uses dual-rail NRZ format.
// - Global reset makes data bus and GPIO pins inputs; channel reset not.
// - Global reset resets all state machines; channel reset only its own.
// - Global reset masks all interrupts; channel reset masks only its own.
// - Global reset returns every register to its default except the status power-on-done bit.
// - With reference clock, power-on reset ends within one millisecond.
// - Without reference clock, power-on reset holds until the clock appears.
// - Device stays in reset while the reset pin is held low.
// - Any write to global reset register starts reset ending within 1 us.
// - Writing one to config bit 1 starts a channel reset within 1 us.
// - Channel reset bit clears itself when the channel reset ends.
// - Channel reset restores channel registers except line standard bit 0.
// - Channel reset leaves global registers, common logic and data bus and GPIO pins alone.
// - A channel reset has no effect on other channels.
// - Channel config: bit 0 line standard, bit 1 reset, base index 0x001.
// - Global reset register is eight bits at index 0x040.
`timescale 1ns/10ps
module drc_top #(
    parameter int unsigned POR_CYCLES = drc_pkg::POR_CYC
) (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic                       mclk_present,
    input  wire logic                       hw_reset_n,
    input  wire logic [drc_pkg::AW-1:0]     s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [drc_pkg::AW-1:0]     s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    output logic                            common_rst_n,
    output logic [drc_pkg::NUM_CH-1:0]      chan_rst_n,
    output logic [drc_pkg::NUM_CH-1:0]      line_hiz,
    output logic [drc_pkg::NUM_CH-1:0]      line_standard_sel,
    output logic [drc_pkg::NUM_CH-1:0]      sys_single_rail,
    output logic [drc_pkg::NUM_CH-1:0]      chan_int_en,
    output logic [drc_pkg::GPIO_N-1:0]      gpio_oe,
    output logic                            dbus_oe
);

    localparam int NCH = drc_pkg::NUM_CH;
    localparam int CW  = drc_pkg::CNT_W;
    localparam int HW_ = drc_pkg::CH_CNT_W;
    localparam logic [CW-1:0]  POR_LAST = CW'(POR_CYCLES - 1);
    localparam logic [CW-1:0]  SW_LAST  = CW'(drc_pkg::SW_RST_CYC - 1);
    localparam logic [HW_-1:0] CH_LOAD  = HW_'(drc_pkg::SW_RST_CYC);

    // ****************************************
    // Address decode helpers
    // ****************************************
    function automatic logic is_ch_cfg(input logic [drc_pkg::AW-1:0] a);
        logic [drc_pkg::IDX_W-1:0] idx;
        idx = a[drc_pkg::AW-1:2];
        is_ch_cfg = (idx[drc_pkg::CH_IDX_LSB-1:0]
                     == drc_pkg::IDX_CH_CFG[drc_pkg::CH_IDX_LSB-1:0]);
    endfunction

    function automatic logic [3:0] chan_of(input logic [drc_pkg::AW-1:0] a);
        logic [drc_pkg::IDX_W-1:0] idx;
        idx = a[drc_pkg::AW-1:2];
        chan_of = idx[drc_pkg::IDX_W-1:drc_pkg::CH_IDX_LSB];
    endfunction

    // ****************************************
    // Power-on reset release
    // ****************************************
    logic rst_meta_q;
    logic rst_sync_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // ****************************************
    // Global reset sequencer
    // ****************************************
    drc_pkg::drc_state_t state_q;
    drc_pkg::drc_state_t state_d;
    logic [CW-1:0]       gcnt_q;
    logic                gsw_pend_q;
    logic                gsw_go;
    logic                glob_rst;

    assign glob_rst = (state_q != drc_pkg::DRC_RUN);

    always_comb begin
        state_d = state_q;
        case (state_q)
            drc_pkg::DRC_POR_WAIT: begin
                if (mclk_present) state_d = drc_pkg::DRC_POR_CNT;
            end
            drc_pkg::DRC_POR_CNT: begin
                if (!mclk_present) begin
                    state_d = drc_pkg::DRC_POR_WAIT;
                end else if (gcnt_q == POR_LAST) begin
                    state_d = drc_pkg::DRC_RUN;
                end
            end
            drc_pkg::DRC_RUN: begin
                if (!hw_reset_n) begin
                    state_d = drc_pkg::DRC_HW;
                end else if (gsw_go) begin
                    state_d = drc_pkg::DRC_GSW;
                end
            end
            drc_pkg::DRC_HW: begin
                if (hw_reset_n) state_d = drc_pkg::DRC_RUN;
            end
            drc_pkg::DRC_GSW: begin
                if (!hw_reset_n) begin
                    state_d = drc_pkg::DRC_HW;
                end else if (gcnt_q == SW_LAST) begin
                    state_d = drc_pkg::DRC_RUN;
                end
            end
            default: state_d = drc_pkg::DRC_POR_WAIT;
        endcase
    end

    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            state_q <= drc_pkg::DRC_POR_WAIT;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            gcnt_q <= '0;
        end else if (state_d != state_q) begin
            gcnt_q <= '0;
        end else if (state_q == drc_pkg::DRC_POR_CNT
                     || state_q == drc_pkg::DRC_GSW) begin
            gcnt_q <= gcnt_q + 1'b1;
        end
    end

    // ****************************************
    // AXI4-Lite write path
    // ****************************************
    logic [drc_pkg::AW-1:0] awaddr_q;
    logic                   aw_hold_q;
    logic [31:0]            wdata_q;
    logic                   wstrb0_q;
    logic                   w_hold_q;
    logic                   wr_go;
    logic                   wr_ch;
    logic [3:0]             wr_cn;
    logic                   wr_idx_ok;
    logic                   rd_busy;

    assign wr_go  = aw_hold_q && w_hold_q && !s_axi_bvalid;
    assign wr_ch  = is_ch_cfg(awaddr_q);
    assign wr_cn  = chan_of(awaddr_q);
    assign wr_idx_ok = wr_ch
        || awaddr_q[drc_pkg::AW-1:2] == drc_pkg::IDX_GLOB_RST
        || awaddr_q[drc_pkg::AW-1:2] == drc_pkg::IDX_IOCTL
        || awaddr_q[drc_pkg::AW-1:2] == drc_pkg::IDX_STATUS;
    assign rd_busy = s_axi_rvalid || (s_axi_arready && s_axi_arvalid);
    assign gsw_go = gsw_pend_q && !s_axi_bvalid && !rd_busy;

    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            aw_hold_q     <= 1'b0;
            awaddr_q      <= '0;
            s_axi_awready <= 1'b0;
        end else if (glob_rst) begin
            aw_hold_q     <= 1'b0;
            s_axi_awready <= 1'b0;
        end else if (s_axi_awready && s_axi_awvalid) begin
            aw_hold_q     <= 1'b1;
            awaddr_q      <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else begin
            if (wr_go) aw_hold_q <= 1'b0;
            s_axi_awready <= !aw_hold_q && !gsw_pend_q;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            w_hold_q     <= 1'b0;
            wdata_q      <= '0;
            wstrb0_q     <= 1'b0;
            s_axi_wready <= 1'b0;
        end else if (glob_rst) begin
            w_hold_q     <= 1'b0;
            s_axi_wready <= 1'b0;
        end else if (s_axi_wready && s_axi_wvalid) begin
            w_hold_q     <= 1'b1;
            wdata_q      <= s_axi_wdata;
            wstrb0_q     <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
        end else begin
            if (wr_go) w_hold_q <= 1'b0;
            s_axi_wready <= !w_hold_q && !gsw_pend_q;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= drc_pkg::RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_idx_ok ? drc_pkg::RESP_OKAY
                                      : drc_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Global reset waits until the write answer and any read have finished
    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            gsw_pend_q <= 1'b0;
        end else if (glob_rst) begin
            gsw_pend_q <= 1'b0;
        end else if (wr_go && awaddr_q[drc_pkg::AW-1:2]
                     == drc_pkg::IDX_GLOB_RST) begin
            gsw_pend_q <= 1'b1;
        end
    end

    // ****************************************
    // Global registers
    // ****************************************
    logic [drc_pkg::GRST_W-1:0] grst_q;
    logic                       por_done_q;

    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            grst_q  <= '0;
            gpio_oe <= '0;
            dbus_oe <= 1'b0;
        end else if (glob_rst) begin
            grst_q  <= '0;
            gpio_oe <= '0;
            dbus_oe <= 1'b0;
        end else if (wr_go && wstrb0_q) begin
            if (awaddr_q[drc_pkg::AW-1:2] == drc_pkg::IDX_GLOB_RST) begin
                grst_q <= wdata_q[drc_pkg::GRST_W-1:0];
            end else if (awaddr_q[drc_pkg::AW-1:2] == drc_pkg::IDX_IOCTL) begin
                gpio_oe <= wdata_q[drc_pkg::IO_GPIO_LSB +: drc_pkg::GPIO_N];
                dbus_oe <= wdata_q[drc_pkg::IO_DBUS];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            por_done_q <= 1'b0;
        end else if (state_q == drc_pkg::DRC_POR_CNT
                     && state_d == drc_pkg::DRC_RUN) begin
            por_done_q <= 1'b1;
        end
    end

    // ****************************************
    // Per-channel configuration and reset
    // ****************************************
    logic [HW_-1:0] ch_cnt_q [NCH];
    logic [NCH-1:0] ch_act;

    for (genvar i = 0; i < NCH; i++) begin : g_ch
        logic wr_me;
        assign ch_act[i] = (ch_cnt_q[i] != '0);
        assign wr_me = wr_go && wstrb0_q && wr_ch && (wr_cn == 4'(i))
                       && !ch_act[i];

        always_ff @(posedge clk or negedge rst_sync_q) begin
            if (!rst_sync_q) begin
                ch_cnt_q[i] <= '0;
            end else if (glob_rst) begin
                ch_cnt_q[i] <= '0;
            end else if (wr_me && wdata_q[drc_pkg::CF_RST]) begin
                ch_cnt_q[i] <= CH_LOAD;
            end else if (ch_act[i]) begin
                ch_cnt_q[i] <= ch_cnt_q[i] - 1'b1;
            end
        end

        always_ff @(posedge clk or negedge rst_sync_q) begin
            if (!rst_sync_q) begin
                line_standard_sel[i] <= 1'b0;
            end else if (glob_rst) begin
                line_standard_sel[i] <= 1'b0;
            end else if (wr_me) begin
                line_standard_sel[i] <= wdata_q[drc_pkg::CF_STD];
            end
        end

        always_ff @(posedge clk or negedge rst_sync_q) begin
            if (!rst_sync_q) begin
                sys_single_rail[i] <= 1'b0;
                chan_int_en[i]     <= 1'b0;
            end else if (glob_rst || (wr_me && wdata_q[drc_pkg::CF_RST])) begin
                sys_single_rail[i] <= 1'b0;
                chan_int_en[i]     <= 1'b0;
            end else if (wr_me) begin
                sys_single_rail[i] <= wdata_q[drc_pkg::CF_SYS];
                chan_int_en[i]     <= wdata_q[drc_pkg::CF_IE];
            end
        end

        always_ff @(posedge clk or negedge rst_sync_q) begin
            if (!rst_sync_q) begin
                chan_rst_n[i] <= 1'b0;
                line_hiz[i]   <= 1'b1;
            end else begin
                chan_rst_n[i] <= !(glob_rst || ch_act[i]);
                line_hiz[i]   <= glob_rst || ch_act[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            common_rst_n <= 1'b0;
        end else begin
            common_rst_n <= !glob_rst;
        end
    end

    // ****************************************
    // AXI4-Lite read path
    // ****************************************
    logic [31:0] rd_data;
    logic        rd_err;

    always_comb begin
        rd_data = '0;
        rd_err  = 1'b0;
        if (is_ch_cfg(s_axi_araddr)) begin
            rd_data[drc_pkg::CF_STD] = line_standard_sel[chan_of(s_axi_araddr)];
            rd_data[drc_pkg::CF_RST] = ch_act[chan_of(s_axi_araddr)];
            rd_data[drc_pkg::CF_SYS] = sys_single_rail[chan_of(s_axi_araddr)];
            rd_data[drc_pkg::CF_IE]  = chan_int_en[chan_of(s_axi_araddr)];
        end else if (s_axi_araddr[drc_pkg::AW-1:2] == drc_pkg::IDX_GLOB_RST) begin
            rd_data[drc_pkg::GRST_W-1:0] = grst_q;
        end else if (s_axi_araddr[drc_pkg::AW-1:2] == drc_pkg::IDX_IOCTL) begin
            rd_data[drc_pkg::IO_GPIO_LSB +: drc_pkg::GPIO_N] = gpio_oe;
            rd_data[drc_pkg::IO_DBUS] = dbus_oe;
        end else if (s_axi_araddr[drc_pkg::AW-1:2] == drc_pkg::IDX_STATUS) begin
            rd_data[drc_pkg::ST_POR_DONE] = por_done_q;
            rd_data[drc_pkg::ST_HW]       = !hw_reset_n;
            rd_data[drc_pkg::ST_MCLK]     = mclk_present;
            rd_data[drc_pkg::ST_CH_LSB +: NCH] = ch_act;
        end else begin
            rd_err = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= drc_pkg::RESP_OKAY;
        end else if (glob_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
        end else if (s_axi_arready && s_axi_arvalid) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_data;
            s_axi_rresp   <= rd_err ? drc_pkg::RESP_SLVERR
                                    : drc_pkg::RESP_OKAY;
        end else begin
            if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
            s_axi_arready <= !s_axi_rvalid && !gsw_pend_q;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_sync_q);

    sequence s_ch0_start;
        !ch_act[0] ##1 ch_act[0];
    endsequence

    sequence s_gsw_start;
        state_q != drc_pkg::DRC_GSW ##1 state_q == drc_pkg::DRC_GSW;
    endsequence

    chk_ch_selfclear: assert property (
        s_ch0_start |-> ch_act[0][*8] ##[1:13] !ch_act[0])
        else $error("channel reset bit did not clear in time");

    chk_gsw_length: assert property (
        s_gsw_start |-> ##[1:20] state_q != drc_pkg::DRC_GSW)
        else $error("global software reset too long");

    chk_por_hold: assert property (
        (state_q == drc_pkg::DRC_POR_WAIT && !mclk_present)
        |=> state_q == drc_pkg::DRC_POR_WAIT ##1 !common_rst_n)
        else $error("power-on reset left without reference clock");

    chk_pin_hold: assert property (
        !hw_reset_n |-> ##2 !common_rst_n)
        else $error("pin reset did not hold device");

    chk_line_hiz: assert property (
        glob_rst |=> line_hiz == '1 && chan_rst_n == '0)
        else $error("line pins not high impedance in reset");

    chk_std_kept: assert property (
        s_ch0_start |=> ($stable(line_standard_sel[0]) || $past(glob_rst)) [*8])
        else $error("line standard changed by channel reset");

    chk_other_chan: assert property (
        s_ch0_start |-> !$rose(ch_act[1]) && $stable(chan_int_en[1]))
        else $error("channel reset disturbed another channel");

    chk_glob_defaults: assert property (
        glob_rst |=> line_standard_sel == '0 && chan_int_en == '0
                     && sys_single_rail == '0 && gpio_oe == '0 && !dbus_oe)
        else $error("register not at default after global reset");

    chk_common_keep: assert property (
        (s_ch0_start ##0 !glob_rst) |-> common_rst_n && $stable(gpio_oe))
        else $error("channel reset touched common logic");

endmodule

// ==== test/drc_board_model.sv ====
// Board supervisor model: reset pin and reference clock detect
`timescale 1ns/10ps
module drc_board_model (
    input  wire logic clk,
    input  wire logic hw_go,
    input  wire logic mclk_on,
    output logic      hw_reset_n,
    output logic      mclk_present
);
    // ****
    // Pin pulse, longer than 1 us at 20 MHz
    // ****
    localparam int LOW_CYC = 30;
    int            cnt     = 0;

    always @(posedge clk) begin
        if (hw_go && cnt == 0) begin
            cnt <= LOW_CYC;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end

    assign hw_reset_n   = (cnt == 0);
    assign mclk_present = mclk_on;
endmodule

// ==== test/device_reset_control_tb.sv ====
// Self-checking bench for the reset sequencer
`timescale 1ns/10ps
module device_reset_control_tb;
    // ****
    // Signals
    // ****
    logic        clk = 0, rst_n = 0, hw_go = 0, mclk_on = 1;
    logic        awvalid = 0, wvalid = 0, bready = 0;
    logic        arvalid = 0, rready = 0;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d, rd;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        common_rst_n, dbus_oe, mclk_present, hw_reset_n;
    logic [1:0]  bresp, rresp, gpio_oe, rs;
    logic [15:0] chan_rst_n, line_hiz, lsel, srail, int_en;
    int          num_errors = 0, compares = 0, seed = 32'ha482, ch, oc;

    always #25 clk = ~clk;

    drc_board_model brd_u (.clk(clk), .hw_go(hw_go), .mclk_on(mclk_on),
        .hw_reset_n(hw_reset_n), .mclk_present(mclk_present));

    drc_top #(.POR_CYCLES(50)) dut_u (.clk(clk), .rst_n(rst_n),
        .mclk_present(mclk_present), .hw_reset_n(hw_reset_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .common_rst_n(common_rst_n), .chan_rst_n(chan_rst_n),
        .line_hiz(line_hiz), .line_standard_sel(lsel),
        .sys_single_rail(srail), .chan_int_en(int_en),
        .gpio_oe(gpio_oe), .dbus_oe(dbus_oe));

    // ****
    // Tasks
    // ****
    task automatic close_out;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s, e);
        compares++;
        if (s !== e) begin
            num_errors++;
            $display("mismatch %s exp %h seen %h", nm, e, s);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wt_rdy;
        int n;
        n = 0;
        while (awready !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        chk("ready wait", n < 2000, 1);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
        end while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 0;
    endtask

    task automatic rdt(input logic [11:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 0;
        end while (rvalid !== 1'b1);
        rd = rdata;
        rs = rresp;
        rready <= 0;
    endtask

    // ****
    // Scenarios
    // ****
    initial begin
        cyc(12);
        rst_n <= 1;
        wt_rdy;
        chk("hiz", line_hiz, 0);
        chk("lsel", lsel, 0);
        chk("rail", srail, 0);
        chk("pins", {gpio_oe, dbus_oe}, 0);
        chk("int", int_en, 0);
        rdt(12'hff0);
        chk("status", rd & 32'h7, 32'h5);
        rdt(12'h008);
        chk("unmapped", rs, 2'h2);
        wr(12'hff4, 32'h7);
        ch = $unsigned($random(seed)) % 16;
        oc = ch ^ 1;
        d = $random(seed) & 32'hd;
        wr(12'(4 + oc * 256), 32'hd);
        wr(12'(4 + ch * 256), d | 32'h2);
        cyc(2);
        chk("ch rst", chan_rst_n, 16'(~(16'h1 << ch)));
        chk("ch hiz", line_hiz, 16'h1 << ch);
        chk("common", common_rst_n, 1);
        cyc(25);
        rdt(12'(4 + ch * 256));
        chk("cfg", rd, {31'h0, d[0]});
        chk("lsel", lsel, (32'(d[0]) << ch) | (1 << oc));
        chk("rail", srail, 1 << oc);
        chk("int", int_en, 1 << oc);
        chk("pins", {gpio_oe, dbus_oe}, 3'h7);
        wr(12'h004, 32'h3);
        rdt(12'hff0);
        chk("ch0 busy", rd[16], 1);
        cyc(20);
        rdt(12'h004);
        chk("ch0 cfg", rd, 32'h1);
        wr(12'h100, $random(seed));
        chk("bresp", rs, 2'h0);
        cyc(3);
        chk("gsw", {common_rst_n, line_hiz}, 17'hffff);
        wt_rdy;
        chk("lsel", lsel, 0);
        chk("pins", {gpio_oe, dbus_oe}, 0);
        hw_go <= 1;
        cyc(1);
        hw_go <= 0;
        cyc(20);
        chk("pin", {common_rst_n, chan_rst_n}, 0);
        wt_rdy;
        mclk_on <= 0;
        rst_n <= 0;
        cyc(2);
        rst_n <= 1;
        cyc(150);
        chk("no mclk", common_rst_n, 0);
        mclk_on <= 1;
        wt_rdy;
        chk("por", common_rst_n, 1);
        close_out;
    end

    initial begin
        cyc(20000);
        num_errors++;
        close_out;
    end
endmodule
